// file: design/flash_cmd_consts.vh
// Constants for the identification, security register and reset command block.
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
// Opcodes.
`define OP_WRITE_ENABLE_COMMAND 8'h06
`define OP_ID_SHORT 8'h90
`define OP_ID_THREE 8'h9F
`define OP_UNIQUE 8'h4B
`define OP_SEC_ERASE 8'h44
`define OP_SEC_PROG 8'h42
`define OP_SEC_READ 8'h48
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
// Security register address decode.
`define SEC_HI_ZERO 8'h00
`define SEC_SEL_TWO 4'h2
`define SEC_SEL_THREE 4'h3
`define SEC_PAGE_BITS 2'h0
`define SEC_BYTES 1024
`define SEC_LAST 10'h3FF
`define SEC_FIRST 10'h000
// Frame lengths in link clock bits.
`define BITS_OP 8
`define BITS_DUMMY 8
`define BITS_ADDR3 6'h18
`define BITS_ADDR4 6'h20
// Timing: times in ns and their counts at 100 MHz.
`define CLK_NS 10
`define T_SEC_ERASE_NS 2000
`define T_SEC_PROG_NS 1000
`define T_RESET_NS 500
`define CYC_SEC_ERASE (`T_SEC_ERASE_NS / `CLK_NS)
`define CYC_SEC_PROG (`T_SEC_PROG_NS / `CLK_NS)
`define CYC_RESET (`T_RESET_NS / `CLK_NS)
// Erased byte value.
`define ERASED_BYTE 8'hFF
`endif

// file: design/link_sync.v
// Three-stage synchroniser for the serial link pins with agreement detection.
`timescale 1ns/1ns
module link_sync #(
  parameter W = 3
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_level,
  output wire [W-1:0] o_rise,
  output wire [W-1:0] o_fall
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  // A level is accepted only when stages two and three agree, so a pin
  // caught mid-transition never counts twice.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
      o_level <= {W{1'b1}};
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      o_level <= (s2_ff & s3_ff) | (o_level & (s2_ff | s3_ff));
    end
  end

  // Edges are derived from stages two and three against the agreed level.
  assign o_rise = (s2_ff & s3_ff) & ~o_level;
  assign o_fall = ~(s2_ff | s3_ff) & o_level;
endmodule

// file: design/byte_skid.v
// Two-entry buffer with valid and ready on both sides for outgoing bytes.
`timescale 1ns/1ns
module byte_skid #(
  parameter WIDTH = 8
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg wp_ff;
  reg rp_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data = mem_ff[rp_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointer and count update; flush drops any stale bytes at frame end.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (i_flush) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) wp_ff <= ~wp_ff;
      if (pop) rp_ff <= ~rp_ff;
      if (push && !pop) cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push) cnt_ff <= cnt_ff - 2'h1;
    end
  end

  // Storage needs no reset; it is only read while the count says valid.
  always @(posedge i_clk_sys) begin
    if (push) mem_ff[wp_ff] <= i_in_data;
  end
endmodule

// file: design/flash_id_secreg.v
// Command interpreter for identification, security register and reset commands.
// Operation
// R1 - Host sends 90h then a 24-bit all-zero address for the short ID.
// R2 - Short ID returns maker then part byte, MSB first, on falling edges.
// R3 - 9Fh returns maker, memory type and capacity bytes, 24 bits.
// R4 - 9Fh during an erase or program is not decoded; the cycle continues.
// R5 - Host avoids 9Fh while the device is in deep power-down.
// R6 - Chip select high ends the ID read anytime; device returns to standby.
// R7 - 4Bh, zero address and a dummy byte return the 128-bit unique value.
// R8 - Host must issue write enable before security erase or program.
// R9 - Erase runs only if select rises after the last address bit.
// R10 - Valid erase starts timed cycle; busy flag set; latch clears before end.
// R11 - A set lock bit refuses erase and program and clears the latch.
// R12 - Two 1024-byte registers, selected by address bits 23 to 10.
// R13 - 42h, address and data bytes; select high starts timed program.
// R14 - Each security register is organised as four pages.
// R15 - 48h, address and dummy byte, then data from any byte.
// R16 - Read address increments per byte, low ten bits wrap 3FF to 000.
// R17 - Host sends 66h in one frame then 99h in the next.
// R18 - Accepted reset aborts operations and clears volatile state bits.
// R19 - During reset recovery every command is refused.
// R20 - Host checks busy and suspend flags before the reset sequence.
// R21 - Reset has no effect in quad DTR continuous read mode.
// R22 - Address phase is 24 bits, or 32 in four-byte mode.
// R23 - Reset accepted only if the preceding frame was the reset enable.
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module flash_id_secreg #(
  parameter [7:0] MAKER_ID = 8'hA5,      // Arbitrary value.
  parameter [7:0] PART_ID = 8'h17,       // Arbitrary value.
  parameter [7:0] MEM_TYPE = 8'h60,      // Arbitrary value.
  parameter [7:0] CAPACITY = 8'h19,      // Arbitrary value.
  parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0011223344556677,
  parameter [15:0] ERASE_CYC = `CYC_SEC_ERASE,
  parameter [15:0] PROG_CYC = `CYC_SEC_PROG,
  parameter [15:0] RESET_CYC = `CYC_RESET
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_si,
  output reg o_so,
  output reg o_so_oe_n,
  input wire i_four_byte_mode,
  input wire i_deep_power_down,
  input wire i_quad_dtr_read,
  input wire i_set_write_enable_latch,
  input wire i_secreg_two_lock,
  input wire i_secreg_three_lock,
  output reg o_write_in_progress_flag,
  output reg o_write_enable_latch,
  output reg o_reset_pulse,
  output reg o_resetting
);
  // ****************************************************************
  // Link sampling
  // ****************************************************************
  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;
  link_sync #(.W(3)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async({i_cs_n, i_sclk, i_si}),
    .o_level(lvl),
    .o_rise(rise),
    .o_fall(fall)
  );
  wire cs_n = lvl[2];
  wire cs_fall = fall[2];
  wire cs_rise = rise[2];
  wire sck_rise = rise[1] && !cs_n;
  wire sck_fall = fall[1] && !cs_n;
  wire si = lvl[0];

  // ****************************************************************
  // State
  // ****************************************************************
  localparam ST_OP = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_DATA_OUT = 3'h3;
  localparam ST_DATA_IN = 3'h4;
  localparam ST_IGNORE = 3'h5;

  localparam OPK_NONE = 3'h0;
  localparam OPK_ID2 = 3'h1;
  localparam OPK_ID3 = 3'h2;
  localparam OPK_UID = 3'h3;
  localparam OPK_ERASE = 3'h4;
  localparam OPK_PROG = 3'h5;
  localparam OPK_READ = 3'h6;

  reg [2:0] st_ff;
  reg [2:0] opk_ff;
  reg [7:0] sh_ff;
  reg [5:0] bit_ff;
  reg [31:0] addr_ff;
  reg [6:0] out_idx_ff;
  reg addr_done_ff;
  reg prog_data_ff;
  reg rst_en_ff;
  reg [15:0] busy_cnt_ff;
  reg [15:0] rst_cnt_ff;
  reg erase_run_ff;
  reg [10:0] erase_ptr_ff;
  reg [7:0] mem [0:2*`SEC_BYTES-1];
  reg [7:0] pbuf [0:255];
  reg [8:0] pcnt_ff;
  reg [7:0] pbase_ff;
  reg [10:0] pbank_ff;
  reg [8:0] pwr_ff;
  reg pwr_run_ff;
  reg [2:0] obit_ff;
  reg load_ff;

  // True when the address selects either security register.
  function sec_hit;
    input [31:0] a;
    input four;
    reg [7:0] hi;
    begin
      hi = four ? (a[31:24] | a[23:16]) : a[23:16];
      sec_hit = (hi == `SEC_HI_ZERO) && (a[11:10] == `SEC_PAGE_BITS) && // [R12]
                (a[15:12] == `SEC_SEL_TWO || a[15:12] == `SEC_SEL_THREE);
    end
  endfunction

  // Word index into the two-register store: bit 10 selects the register.
  function [10:0] sec_index;
    input [31:0] a;
    begin
      sec_index = {a[12], a[9:0]};
    end
  endfunction

  function locked;
    input [31:0] a;
    input l2;
    input l3;
    begin
      locked = a[12] ? l3 : l2;
    end
  endfunction

  wire busy = o_write_in_progress_flag;
  wire [5:0] addr_bits = i_four_byte_mode ? `BITS_ADDR4 : `BITS_ADDR3;  // [R22]
  wire [7:0] op_in = {sh_ff[6:0], si};
  wire [31:0] addr_in = {addr_ff[30:0], si};

  // ****************************************************************
  // Output byte source and buffer
  // ****************************************************************
  reg [7:0] src_byte;
  always @* begin
    src_byte = `ERASED_BYTE;
    case (opk_ff)
      OPK_ID2: src_byte = out_idx_ff[0] ? PART_ID : MAKER_ID;                      // [R2]
      OPK_ID3: src_byte = (out_idx_ff == 7'h0) ? MAKER_ID :
                          (out_idx_ff == 7'h1) ? MEM_TYPE : CAPACITY;            // [R3]
      OPK_UID: src_byte = UNIQUE_ID[8'd127 - {out_idx_ff[3:0], 3'h0} -: 8];      // [R7]
      OPK_READ: src_byte = mem[sec_index(addr_ff)];                             // [R15]
      default: src_byte = `ERASED_BYTE;
    endcase
  end

  wire buf_in_ready;
  wire buf_valid;
  wire [7:0] buf_data;
  reg buf_pop;
  wire want_load = (st_ff == ST_DATA_OUT) && buf_in_ready && !load_ff;
  byte_skid #(.WIDTH(8)) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_flush(cs_n),
    .i_in_valid(want_load),
    .o_in_ready(buf_in_ready),
    .i_in_data(src_byte),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_pop),
    .o_out_data(buf_data)
  );

  // ****************************************************************
  // Frame decoder
  // ****************************************************************
  // Bits are taken on rising link edges; data leaves on falling ones.
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= ST_OP;
      opk_ff <= OPK_NONE;
      sh_ff <= 8'h00;
      bit_ff <= 6'h0;
      addr_ff <= 32'h0;
      out_idx_ff <= 7'h0;
      addr_done_ff <= 1'b0;
      prog_data_ff <= 1'b0;
      rst_en_ff <= 1'b0;
      busy_cnt_ff <= 16'h0;
      rst_cnt_ff <= 16'h0;
      erase_run_ff <= 1'b0;
      erase_ptr_ff <= 11'h0;
      pcnt_ff <= 9'h0;
      pbase_ff <= 8'h0;
      pbank_ff <= 11'h0;
      pwr_ff <= 9'h0;
      pwr_run_ff <= 1'b0;
      obit_ff <= 3'h7;
      load_ff <= 1'b0;
      buf_pop <= 1'b0;
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
      o_write_in_progress_flag <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_reset_pulse <= 1'b0;
      o_resetting <= 1'b0;
    end else begin
      o_reset_pulse <= 1'b0;
      buf_pop <= 1'b0;
      load_ff <= want_load;
      if (want_load) out_idx_ff <= out_idx_ff + 7'h1;
      if (want_load && opk_ff == OPK_READ)
        addr_ff[9:0] <= addr_ff[9:0] + 10'h1;                                  // [R16]
      if (i_set_write_enable_latch && !busy) o_write_enable_latch <= 1'b1;
      // Self-timed cycle countdown; latch drops one cycle before the end.
      if (busy_cnt_ff != 16'h0) begin
        busy_cnt_ff <= busy_cnt_ff - 16'h1;
        if (busy_cnt_ff == 16'h2) o_write_enable_latch <= 1'b0;               // [R10]
        if (busy_cnt_ff == 16'h1) o_write_in_progress_flag <= 1'b0;
      end
      // Erase fills one byte per cycle, 1024 bytes; inside the busy time only when ERASE_CYC is 1024 or more.
      if (erase_run_ff) begin
        mem[erase_ptr_ff] <= `ERASED_BYTE;
        erase_ptr_ff[9:0] <= erase_ptr_ff[9:0] + 10'h1;
        if (erase_ptr_ff[9:0] == `SEC_LAST) erase_run_ff <= 1'b0;
      end
      // Program commits buffered page bytes, wrapping inside the page.
      if (pwr_run_ff) begin
        mem[{pbank_ff[10:8], pbase_ff + pwr_ff[7:0]}] <= pbuf[pwr_ff[7:0]];    // [R14]
        pwr_ff <= pwr_ff + 9'h1;
        if (pwr_ff + 9'h1 == pcnt_ff) pwr_run_ff <= 1'b0;
      end
      // Reset recovery countdown.
      if (rst_cnt_ff != 16'h0) begin
        rst_cnt_ff <= rst_cnt_ff - 16'h1;
        if (rst_cnt_ff == 16'h1) o_resetting <= 1'b0;
      end
      if (cs_fall) begin
        st_ff <= (o_resetting) ? ST_IGNORE : ST_OP;                            // [R19]
        bit_ff <= 6'h0;
        opk_ff <= OPK_NONE;
        addr_done_ff <= 1'b0;
        prog_data_ff <= 1'b0;
        out_idx_ff <= 7'h0;
        pcnt_ff <= 9'h0;
        obit_ff <= 3'h7;
      end else if (cs_rise) begin
        o_so_oe_n <= 1'b1;                                                     // [R6]
        st_ff <= ST_OP;
        if (opk_ff == OPK_ERASE && addr_done_ff && st_ff == ST_IGNORE) begin
          // Completed erase frame: run if latched and unlocked.
          if (locked(addr_ff, i_secreg_two_lock, i_secreg_three_lock) ||
              !sec_hit(addr_ff, i_four_byte_mode))
            o_write_enable_latch <= 1'b0;                                      // [R11]
          else if (o_write_enable_latch) begin
            o_write_in_progress_flag <= 1'b1;                                  // [R10]
            busy_cnt_ff <= ERASE_CYC;
            erase_run_ff <= 1'b1;
            erase_ptr_ff <= {addr_ff[12], 10'h000};
          end
        end
        if (opk_ff == OPK_PROG && prog_data_ff) begin
          if (locked(addr_ff, i_secreg_two_lock, i_secreg_three_lock) ||
              !sec_hit(addr_ff, i_four_byte_mode))
            o_write_enable_latch <= 1'b0;                                      // [R11]
          else if (o_write_enable_latch) begin
            o_write_in_progress_flag <= 1'b1;                                  // [R13]
            busy_cnt_ff <= PROG_CYC;
            pwr_run_ff <= 1'b1;
            pwr_ff <= 9'h0;
            pbank_ff <= sec_index(addr_ff);
            pbase_ff <= addr_ff[7:0];
          end
        end
      end else if (sck_rise) begin
        case (st_ff)
          ST_OP: begin
            sh_ff <= op_in;
            bit_ff <= bit_ff + 6'h1;
            if (bit_ff == `BITS_OP - 1) begin
              bit_ff <= 6'h0;
              st_ff <= ST_IGNORE;
              // Reset enable is consumed by the next frame that completes an opcode byte.
              rst_en_ff <= (op_in == `OP_RST_EN) && !i_quad_dtr_read;          // [R23]
              case (op_in)
                `OP_ID_SHORT: if (!busy && !i_deep_power_down) begin
                  opk_ff <= OPK_ID2;
                  st_ff <= ST_ADDR;                                            // [R1]
                end
                `OP_ID_THREE: if (!busy && !i_deep_power_down) begin           // [R4]
                  opk_ff <= OPK_ID3;
                  st_ff <= ST_DATA_OUT;                                        // [R3]
                end
                `OP_UNIQUE: if (!busy) begin
                  opk_ff <= OPK_UID;
                  st_ff <= ST_ADDR;
                end
                `OP_SEC_ERASE: if (!busy) begin
                  opk_ff <= OPK_ERASE;
                  st_ff <= ST_ADDR;
                end
                `OP_SEC_PROG: if (!busy) begin
                  opk_ff <= OPK_PROG;
                  st_ff <= ST_ADDR;
                end
                `OP_SEC_READ: if (!busy) begin
                  opk_ff <= OPK_READ;
                  st_ff <= ST_ADDR;
                end
                `OP_RST: if (rst_en_ff && !i_quad_dtr_read) begin              // [R21]
                  // Abort every internal operation and enter recovery.
                  o_reset_pulse <= 1'b1;                                       // [R18]
                  o_resetting <= 1'b1;
                  rst_cnt_ff <= RESET_CYC;
                  o_write_enable_latch <= 1'b0;
                  o_write_in_progress_flag <= 1'b0;
                  busy_cnt_ff <= 16'h0;
                  erase_run_ff <= 1'b0;
                  pwr_run_ff <= 1'b0;
                end
                default: st_ff <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr_ff <= addr_in;
            bit_ff <= bit_ff + 6'h1;
            if (bit_ff == ((opk_ff == OPK_ID2) ? `BITS_ADDR3 : addr_bits) - 1) begin
              bit_ff <= 6'h0;
              addr_done_ff <= 1'b1;                                            // [R9]
              if (!i_four_byte_mode || opk_ff == OPK_ID2) addr_ff <= {8'h00, addr_in[23:0]};
              case (opk_ff)
                OPK_ID2: st_ff <= ST_DATA_OUT;
                OPK_UID, OPK_READ: st_ff <= ST_DUMMY;                          // [R7]
                OPK_PROG: st_ff <= ST_DATA_IN;
                default: st_ff <= ST_IGNORE;
              endcase
            end
          end
          ST_DUMMY: begin
            bit_ff <= bit_ff + 6'h1;
            if (bit_ff == `BITS_DUMMY - 1) st_ff <= ST_DATA_OUT;
          end
          ST_DATA_IN: begin
            sh_ff <= op_in;
            bit_ff <= bit_ff + 6'h1;
            if (bit_ff == `BITS_OP - 1) begin
              bit_ff <= 6'h0;
              // A page holds 256 bytes; bytes beyond the 256th all overwrite the first entry.
              pbuf[pcnt_ff[7:0]] <= op_in;
              prog_data_ff <= 1'b1;
              if (pcnt_ff != 9'h100) pcnt_ff <= pcnt_ff + 9'h1;
            end
          end
          default: st_ff <= st_ff;
        endcase
      end else if (sck_fall && st_ff == ST_DATA_OUT && buf_valid) begin
        // Shift the head byte out MSB first; pop after its last bit.
        o_so_oe_n <= 1'b0;
        o_so <= buf_data[obit_ff];                                             // [R2]
        obit_ff <= obit_ff - 3'h1;
        if (obit_ff == 3'h0) buf_pop <= 1'b1;
      end
    end
  end
endmodule

// file: tb/flash_host_model.sv
// Host serial controller model that frames commands on the link pins.
`timescale 1ns/1ns
module flash_host_model (
  input wire i_clk_sys,
  input wire i_so,
  input wire i_so_oe_n,
  output reg o_cs_n,
  output reg o_sclk,
  output reg o_si
);
  // ****************
  // Link tasks
  // ****************
  // The link clock idles low outside frames; a half period is four cycles, 40 ns.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  task sel;
    begin
      repeat (4) @(negedge i_clk_sys);
      o_cs_n = 1'b0;
    end
  endtask
  // Output is sampled just before the next fall, so a late driver is still seen.
  task xfer(input [7:0] t, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        o_si = t[i];
        repeat (4) @(negedge i_clk_sys);
        o_sclk = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        r[i] = i_so_oe_n ? 1'bz : i_so;
        o_sclk = 1'b0;
      end
    end
  endtask
  // A released data line is flipped so that a stale level is never mistaken for data.
  task desel;
    begin
      repeat (4) @(negedge i_clk_sys);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (8) @(negedge i_clk_sys);
    end
  endtask
endmodule

// file: tb/flash_id_secreg_asserts.sv
// Concurrent checks on the status and output pins of the command block.
`timescale 1ns/1ns
module flash_id_secreg_asserts #(
  parameter [15:0] ERASE_CYC = 16'h00C8,
  parameter [15:0] RESET_CYC = 16'h0032
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_cs_n,
  input wire i_secreg_two_lock,
  input wire i_secreg_three_lock,
  input wire o_so_oe_n,
  input wire o_write_in_progress_flag,
  input wire o_write_enable_latch,
  input wire o_reset_pulse,
  input wire o_resetting
);
  // ****************
  // Checks
  // ****************
  localparam int RST_MAX = RESET_CYC + 4;
  reg [15:0] busy_ff;
  wire [15:0] nxt_busy;
  // Busy length is counted here, since it is too long for a repetition.
  assign nxt_busy = o_write_in_progress_flag ? busy_ff + 16'h0001 : 16'h0000;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_ff <= 16'h0000;
    end else begin
      busy_ff <= nxt_busy;
    end
  end
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_oe_off_deselect: assert property (i_cs_n [*6] |-> o_so_oe_n)
    else $error("output driven while deselected");
  a_pulse_single: assert property (o_reset_pulse |=> !o_reset_pulse)
    else $error("reset pulse too long");
  a_pulse_recovery: assert property (o_reset_pulse |-> ##[0:1] o_resetting)
    else $error("no recovery after reset");
  a_recovery_ends: assert property ($rose(o_resetting) |-> ##[1:RST_MAX] !o_resetting)
    else $error("recovery too long");
  a_reset_clears: assert property ($rose(o_resetting) |->
    ##[0:2] (!o_write_in_progress_flag && !o_write_enable_latch)) else $error("reset left state");
  a_busy_needs_wel: assert property ($rose(o_write_in_progress_flag) |->
    o_write_enable_latch) else $error("busy without latch");
  a_wel_before_done: assert property ($fell(o_write_in_progress_flag) && !o_resetting
    && !o_reset_pulse |-> !$past(o_write_enable_latch)) else $error("latch late");
  a_locked_idle: assert property (i_secreg_two_lock && i_secreg_three_lock
    |-> !$rose(o_write_in_progress_flag)) else $error("locked cycle ran");
  a_busy_bounded: assert property (busy_ff <= ERASE_CYC + 16'h0004)
    else $error("busy too long");
  a_busy_quiet: assert property (o_write_in_progress_flag &&
    $past(o_write_in_progress_flag, 2) |-> o_so_oe_n) else $error("output while busy");
endmodule
bind flash_id_secreg flash_id_secreg_asserts #(.ERASE_CYC(ERASE_CYC), .RESET_CYC(RESET_CYC))
  u_chk (.i_clk_sys, .i_resetn, .i_cs_n, .i_secreg_two_lock, .i_secreg_three_lock, .o_so_oe_n,
  .o_write_in_progress_flag, .o_write_enable_latch, .o_reset_pulse, .o_resetting);

// file: tb/flash_id_secreg_tb_top.sv
// Self-checking bench for the identification, security register and reset commands.
`timescale 1ns/1ns
`include "flash_cmd_consts.vh"
module flash_id_secreg_tb_top;
  // ****************
  // Design and clock
  // ****************
  localparam [7:0] MK = 8'h3C; // Arbitrary value.
  localparam [7:0] PT = 8'h4E; // Arbitrary value.
  localparam [7:0] MT = 8'h71; // Arbitrary value.
  localparam [7:0] CP = 8'h18; // Arbitrary value.
  localparam [127:0] UID = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
  reg clk, resetn, fbm, qdtr, setwel, lk2, lk3;
  wire cs_n, sclk, si, so, oe_n, write_in_progress_flag, write_enable_latch, rpulse, rsting;
  integer fails, samples_checked, pulses;
  // Erase is kept at 1100 cycles so that a full register fill fits; recovery is long.
  flash_id_secreg #(.MAKER_ID(MK), .PART_ID(PT), .MEM_TYPE(MT), .CAPACITY(CP),
    .UNIQUE_ID(UID), .ERASE_CYC(16'h044C), .PROG_CYC(16'h0014), .RESET_CYC(16'h00C8)) DUT (
    .i_clk_sys(clk), .i_resetn(resetn), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si), .o_so(so),
    .o_so_oe_n(oe_n), .i_four_byte_mode(fbm), .i_deep_power_down(1'b0),
    .i_quad_dtr_read(qdtr), .i_set_write_enable_latch(setwel), .i_secreg_two_lock(lk2),
    .i_secreg_three_lock(lk3), .o_write_in_progress_flag(write_in_progress_flag), .o_write_enable_latch(write_enable_latch),
    .o_reset_pulse(rpulse), .o_resetting(rsting));
  flash_host_model host (.i_clk_sys(clk), .i_so(so), .i_so_oe_n(oe_n), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_si(si));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Accepted resets are counted, as the pulse lasts a single cycle.
  always @(posedge clk) begin
    if (rpulse === 1'b1) pulses = pulses + 1;
  end
  // ****************
  // Helpers
  // ****************
  task check(input string what, input [127:0] exp, input [127:0] seen);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cmd(input [7:0] c, input [31:0] adr, input integer na, input integer nd);
    integer k;
    reg [7:0] r;
    begin
      host.sel;
      host.xfer(c, r);
      for (k = na - 1; k >= 0; k = k - 1)
        host.xfer(adr[8*k +: 8], r);
      repeat (nd) host.xfer(8'hA5, r);
    end
  endtask
  task rd(input integer n, output [127:0] v);
    reg [7:0] r;
    begin
      v = 128'h0;
      repeat (n) begin
        host.xfer(8'h00, r);
        v = {v[119:0], r};
      end
    end
  endtask
  task op(input [7:0] c);
    begin
      cmd(c, 32'h0, 0, 0);
      host.desel;
    end
  endtask
  task rdsec(input [31:0] adr, input integer n, output [127:0] v);
    begin
      cmd(`OP_SEC_READ, adr, 3, 1);
      rd(n, v);
      host.desel;
    end
  endtask
  task wel_on;
    begin
      setwel = 1'b1;
      @(negedge clk);
      setwel = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  task wait_idle;
    integer k;
    begin
      for (k = 0; k < 3000 && write_in_progress_flag !== 1'b0; k = k + 1)
        @(negedge clk);
      check("wip_done", 1'b0, write_in_progress_flag);
    end
  endtask
  task prog(input [31:0] adr, input [15:0] d);
    reg [7:0] r;
    begin
      cmd(`OP_SEC_PROG, adr, 3, 0);
      host.xfer(d[15:8], r);
      host.xfer(d[7:0], r);
      host.desel;
      wait_idle;
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_ids;
    reg [127:0] v;
    begin
      cmd(`OP_ID_SHORT, 32'h0, 3, 0);
      rd(2, v);
      host.desel;
      check("short_id", {MK, PT}, v);
      cmd(`OP_ID_THREE, 32'h0, 0, 0);
      rd(3, v);
      host.desel;
      check("three_id", {MK, MT, CP}, v);
      check("oe_idle", 1'b1, oe_n);
      fbm = 1'b1;
      cmd(`OP_UNIQUE, 32'h0, 4, 1);
      rd(16, v);
      host.desel;
      fbm = 1'b0;
      check("unique", UID, v);
      $display("Test ids done");
    end
  endtask
  task t_secreg;
    reg [127:0] v;
    begin
      wel_on;
      cmd(`OP_SEC_ERASE, 32'h002000, 2, 0);
      host.desel;
      check("short_erase", 1'b0, write_in_progress_flag);
      wel_on;
      cmd(`OP_SEC_ERASE, 32'h002000, 3, 0);
      host.desel;
      check("erase_busy", 1'b1, write_in_progress_flag);
      cmd(`OP_ID_THREE, 32'h0, 0, 0);
      rd(1, v);
      host.desel;
      check("busy_id", {120'h0, 8'hZZ}, v);
      check("busy_kept", 1'b1, write_in_progress_flag);
      wait_idle;
      check("erase_wel", 1'b0, write_enable_latch);
      wel_on;
      prog(32'h0023FE, 16'h5AC3);
      check("prog_wel", 1'b0, write_enable_latch);
      wel_on;
      prog(32'h0022FF, 16'h1122);
      rdsec(32'h0023FE, 4, v);
      check("wrap_read", {96'h0, 32'h5AC3FFFF}, v);
      rdsec(32'h0022FF, 2, v);
      check("page_wrap", {112'h0, 16'h11FF}, v);
      rdsec(32'h002200, 1, v);
      check("page_head", {120'h0, 8'h22}, v);
      $display("Test secreg done");
    end
  endtask
  task t_lock;
    reg [127:0] v;
    begin
      lk2 = 1'b1;
      lk3 = 1'b1;
      wel_on;
      prog(32'h002300, 16'h0000);
      check("lock_wel", 1'b0, write_enable_latch);
      rdsec(32'h002300, 1, v);
      check("lock_data", {120'h0, 8'hFF}, v);
      lk2 = 1'b0;
      lk3 = 1'b0;
      $display("Test lock done");
    end
  endtask
  task t_reset;
    reg [127:0] v;
    integer p, k;
    begin
      p = pulses;
      wait_idle;
      op(`OP_RST_EN);
      op(`OP_ID_THREE);
      op(`OP_RST);
      check("reset_cancel", p, pulses);
      qdtr = 1'b1;
      op(`OP_RST_EN);
      op(`OP_RST);
      qdtr = 1'b0;
      check("reset_dtr", p, pulses);
      wel_on;
      cmd(`OP_SEC_ERASE, 32'h003000, 3, 0);
      host.desel;
      op(`OP_RST_EN);
      op(`OP_RST);
      check("reset_taken", p + 1, pulses);
      check("reset_wip", 1'b0, write_in_progress_flag);
      check("reset_wel", 1'b0, write_enable_latch);
      cmd(`OP_ID_THREE, 32'h0, 0, 0);
      rd(1, v);
      host.desel;
      check("recovery_id", {120'h0, 8'hZZ}, v);
      for (k = 0; k < 400 && rsting !== 1'b0; k = k + 1)
        @(negedge clk);
      cmd(`OP_ID_THREE, 32'h0, 0, 0);
      rd(1, v);
      host.desel;
      check("after_reset", {120'h0, MK}, v);
      $display("Test reset done");
    end
  endtask
  task give_verdict;
    begin
      $display("Checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // The whole run needs some 80 us; the watchdog allows six times that.
  initial begin
    #500000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    {resetn, fbm, qdtr, setwel, lk2, lk3} = 6'h00;
    fails = 0;
    samples_checked = 0;
    pulses = 0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    check("rst_oe", 1'b1, oe_n);
    check("rst_wip", 1'b0, write_in_progress_flag);
    check("rst_wel", 1'b0, write_enable_latch);
    repeat (4) @(negedge clk);
    t_ids;
    t_secreg;
    t_lock;
    t_reset;
    give_verdict;
  end
endmodule
